// File: include/twmt_pkg.sv
package twmt_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_RATE = 8'h0c;

  // bus_control_reg field positions
  localparam int CTRL_FLAG = 7;
  localparam int CTRL_ACK  = 6;
  localparam int CTRL_STA  = 5;
  localparam int CTRL_STO  = 4;
  localparam int CTRL_WC   = 3;
  localparam int CTRL_EN   = 2;
  localparam int CTRL_IE   = 0;

  // bus_status_reg layout
  localparam int STAT_CODE_LSB = 3;
  localparam int STAT_PRESC_W  = 2;

  // status codes, prescaler bits zero
  localparam logic [7:0] CODE_START    = 8'h08;
  localparam logic [7:0] CODE_RSTART   = 8'h10;
  localparam logic [7:0] CODE_SLA_ACK  = 8'h18;
  localparam logic [7:0] CODE_SLA_NACK = 8'h20;
  localparam logic [7:0] CODE_DAT_ACK  = 8'h28;
  localparam logic [7:0] CODE_DAT_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST = 8'h38;
  localparam logic [7:0] CODE_IDLE     = 8'hf8;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hff;

  // timing: one quarter of a bit period on the serial clock
  localparam int CLK_NS      = 50;
  localparam int QUARTER_NS  = 100;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RATE_RESET = 8'(QUARTER_CYC - 1);

  localparam int BYTE_BITS = 8;

  typedef enum logic [1:0] {
    not_addressed_slave  = 2'b00,
    master_transmit_mode = 2'b01,
    master_receive_mode  = 2'b10
  } twmt_mode_e;

  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_WAIT_FREE = 4'h1,
    S_START_A   = 4'h2,
    S_START_B   = 4'h3,
    S_HOLD      = 4'h4,
    S_BIT_LOW   = 4'h5,
    S_BIT_SETUP = 4'h6,
    S_BIT_HIGH  = 4'h7,
    S_STOP_A    = 4'h8,
    S_STOP_B    = 4'h9,
    S_STOP_C    = 4'ha,
    S_RS_A      = 4'hb,
    S_RS_B      = 4'hc,
    S_RS_C      = 4'hd
  } twmt_state_e;

endpackage

// File: hw/twmt_sync.sv
`timescale 1ns/1ps
module twmt_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // async in, synced out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // lines idle high, so reset to one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= '1;
      q       <= '1;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// File: hw/twmt_top.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
module twmt_top
  import twmt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // apb
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // two-wire pins, open drain
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  // interrupt request
  output logic                   irq
);

  if (ADDR_W < 8)
  begin : g_chk
    $error("twmt_top: ADDR_W must be at least 8");
  end

  twmt_state_e state_ff, nxt_state;
  twmt_mode_e  mode_ff, nxt_mode;
  logic [7:0]  shift_ff, nxt_shift;
  logic [3:0]  bit_ff, nxt_bit;
  logic [7:0]  code_ff, nxt_code;
  logic        scl_low_ff, nxt_scl_low;
  logic        sda_low_ff, nxt_sda_low;
  logic        lost_ff, nxt_lost;
  logic        addr_ff, nxt_addr;
  logic        rs_ff, nxt_rs;
  logic        set_flag, clr_stop;
  logic        flag_ff, ack_en_ff, sta_ff, sto_ff, wc_ff, en_ff, ie_ff;
  logic [7:0]  data_ff, rate_ff, cnt_ff;
  logic [STAT_PRESC_W-1:0] presc_ff;
  logic [1:0]  pins_q;
  logic        scl_s, sda_s, sda_prev_ff, busy_ff, tick;
  logic        acc, wr, go, wr_data;

  // apb access phase, one wait state
  assign acc     = psel & penable & pready;
  assign wr      = acc & pwrite;
  assign go      = wr && paddr[7:0] == ADDR_CTRL && pwdata[CTRL_FLAG];
  assign wr_data = wr && paddr[7:0] == ADDR_DATA;

  twmt_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({scl_i, sda_i}),
    .q       (pins_q)
  );
  assign scl_s = pins_q[1];
  assign sda_s = pins_q[0];

  // bus busy between any START and STOP seen on the wires
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_prev_ff <= 1'b1;
      busy_ff     <= 1'b0;
    end
    else
    begin
      sda_prev_ff <= sda_s;
      if (scl_s && sda_prev_ff && !sda_s)
        busy_ff <= 1'b1;
      else if (scl_s && !sda_prev_ff && sda_s)
        busy_ff <= 1'b0;
    end
  end

  // quarter-bit tick divider
  assign tick = (cnt_ff == 8'h00);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 8'h00;
    else if (tick)
      cnt_ff <= rate_ff;
    else
      cnt_ff <= cnt_ff - 8'h01;
  end

  // bus engine
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_mode    = mode_ff;
    nxt_shift   = shift_ff;
    nxt_bit     = bit_ff;
    nxt_code    = code_ff;
    nxt_scl_low = scl_low_ff;
    nxt_sda_low = sda_low_ff;
    nxt_lost    = lost_ff;
    nxt_addr    = addr_ff;
    nxt_rs      = rs_ff;
    set_flag    = 1'b0;
    clr_stop    = 1'b0;
    if (!en_ff)
    begin
      // enable and start may arrive in one write
      nxt_state   = (go && pwdata[CTRL_EN] && pwdata[CTRL_STA]) ? S_WAIT_FREE : S_IDLE;
      nxt_mode    = not_addressed_slave;
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      nxt_lost    = 1'b0;
      nxt_code    = CODE_IDLE;
    end
    else
    begin
      unique case (state_ff)
        S_IDLE:
          if (go && pwdata[CTRL_STA])
            nxt_state = S_WAIT_FREE;
        S_WAIT_FREE:
          if (tick && !busy_ff)
          begin
            nxt_rs      = 1'b0;
            nxt_sda_low = 1'b1;
            nxt_state   = S_START_A;
          end
        S_START_A:
          if (tick)
          begin
            nxt_scl_low = 1'b1;
            nxt_state   = S_START_B;
          end
        S_START_B:
          if (tick)
          begin
            set_flag  = 1'b1;
            nxt_code  = rs_ff ? CODE_RSTART : CODE_START;
            nxt_addr  = 1'b1;
            nxt_state = S_HOLD;
          end
        S_HOLD:
          if (go)
          begin
            if (lost_ff)
            begin
              nxt_lost  = 1'b0;
              nxt_mode  = not_addressed_slave;
              nxt_code  = CODE_IDLE;
              nxt_state = pwdata[CTRL_STA] ? S_WAIT_FREE : S_IDLE;
            end
            else if (pwdata[CTRL_STO])
              nxt_state = S_STOP_A;
            else if (pwdata[CTRL_STA])
              nxt_state = S_RS_A;
            else
            begin
              nxt_shift = data_ff;
              nxt_bit   = 4'd0;
              if (addr_ff)
                nxt_mode = data_ff[0] ? master_receive_mode : master_transmit_mode;
              nxt_state = S_BIT_LOW;
            end
          end
        S_BIT_LOW:
          if (tick)
          begin
            nxt_sda_low = (bit_ff < 4'(BYTE_BITS)) ? !shift_ff[7] : 1'b0;
            nxt_state   = S_BIT_SETUP;
          end
        S_BIT_SETUP:
          if (tick)
          begin
            nxt_scl_low = 1'b0;
            nxt_state   = S_BIT_HIGH;
          end
        S_BIT_HIGH:
          if (tick && scl_s)
          begin
            if (bit_ff < 4'(BYTE_BITS) && !sda_low_ff && !sda_s)
            begin
              nxt_sda_low = 1'b0;
              nxt_lost    = 1'b1;
              nxt_addr    = 1'b0;
              nxt_code    = CODE_ARB_LOST;
              set_flag    = 1'b1;
              nxt_state   = S_HOLD;
            end
            else if (bit_ff == 4'(BYTE_BITS))
            begin
              nxt_scl_low = 1'b1;
              set_flag    = 1'b1;
              nxt_addr    = 1'b0;
              if (addr_ff)
                nxt_code = sda_s ? CODE_SLA_NACK : CODE_SLA_ACK;
              else
                nxt_code = sda_s ? CODE_DAT_NACK : CODE_DAT_ACK;
              nxt_state = S_HOLD;
            end
            else
            begin
              nxt_scl_low = 1'b1;
              nxt_shift   = {shift_ff[6:0], 1'b0};
              nxt_bit     = bit_ff + 4'd1;
              nxt_state   = S_BIT_LOW;
            end
          end
        S_STOP_A:
          if (tick)
          begin
            nxt_sda_low = 1'b1;
            nxt_state   = S_STOP_B;
          end
        S_STOP_B:
          if (tick)
          begin
            nxt_scl_low = 1'b0;
            nxt_state   = S_STOP_C;
          end
        S_STOP_C:
          if (tick && scl_s)
          begin
            nxt_sda_low = 1'b0;
            clr_stop    = 1'b1;
            nxt_code    = CODE_IDLE;
            nxt_mode    = not_addressed_slave;
            nxt_state   = sta_ff ? S_WAIT_FREE : S_IDLE;
          end
        S_RS_A:
          if (tick)
          begin
            nxt_sda_low = 1'b0;
            nxt_state   = S_RS_B;
          end
        S_RS_B:
          if (tick)
          begin
            nxt_scl_low = 1'b0;
            nxt_state   = S_RS_C;
          end
        S_RS_C:
          if (tick && scl_s)
          begin
            nxt_sda_low = 1'b1;
            nxt_rs      = 1'b1;
            nxt_state   = S_START_A;
          end
        default:
          nxt_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff   <= S_IDLE;
      mode_ff    <= not_addressed_slave;
      shift_ff   <= 8'h00;
      bit_ff     <= 4'h0;
      code_ff    <= CODE_IDLE;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      lost_ff    <= 1'b0;
      addr_ff    <= 1'b0;
      rs_ff      <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      mode_ff    <= nxt_mode;
      shift_ff   <= nxt_shift;
      bit_ff     <= nxt_bit;
      code_ff    <= nxt_code;
      scl_low_ff <= nxt_scl_low;
      sda_low_ff <= nxt_sda_low;
      lost_ff    <= nxt_lost;
      addr_ff    <= nxt_addr;
      rs_ff      <= nxt_rs;
    end
  end

  // step-done flag, hardware set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_ff <= CTRL_RESET[CTRL_FLAG];
    else if (set_flag)
      flag_ff <= 1'b1;
    else if (go)
      flag_ff <= 1'b0;
  end

  // control, data, prescaler and rate registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_en_ff <= CTRL_RESET[CTRL_ACK];
      sta_ff    <= CTRL_RESET[CTRL_STA];
      sto_ff    <= CTRL_RESET[CTRL_STO];
      wc_ff     <= CTRL_RESET[CTRL_WC];
      en_ff     <= CTRL_RESET[CTRL_EN];
      ie_ff     <= CTRL_RESET[CTRL_IE];
      data_ff   <= DATA_RESET;
      presc_ff  <= '0;
      rate_ff   <= RATE_RESET;
    end
    else
    begin
      if (wr && paddr[7:0] == ADDR_CTRL)
      begin
        ack_en_ff <= pwdata[CTRL_ACK];
        sta_ff    <= pwdata[CTRL_STA];
        sto_ff    <= pwdata[CTRL_STO];
        en_ff     <= pwdata[CTRL_EN];
        ie_ff     <= pwdata[CTRL_IE];
      end
      else if (clr_stop)
        sto_ff <= 1'b0;
      if (wr_data)
      begin
        if (flag_ff)
        begin
          data_ff <= pwdata[7:0];
          wc_ff   <= 1'b0;
        end
        else
          wc_ff <= 1'b1;
      end
      if (wr && paddr[7:0] == ADDR_STAT)
        presc_ff <= pwdata[STAT_PRESC_W-1:0];
      if (wr && paddr[7:0] == ADDR_RATE)
        rate_ff <= pwdata[7:0];
    end
  end

  // apb answer: ready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready)
      begin
        unique case (paddr[7:0])
          ADDR_CTRL:
            prdata <= {24'h000000, flag_ff, ack_en_ff, sta_ff, sto_ff,
                       wc_ff, en_ff, 1'b0, ie_ff};
          ADDR_STAT:
            prdata <= {24'h000000, code_ff[7:STAT_CODE_LSB], 1'b0, presc_ff};
          ADDR_DATA:
            prdata <= {24'h000000, data_ff};
          ADDR_RATE:
            prdata <= {22'h0, mode_ff, rate_ff};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

  // pins and interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      irq      <= 1'b0;
    end
    else
    begin
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
      scl_oe_n <= !nxt_scl_low;
      sda_oe_n <= !nxt_sda_low;
      irq      <= ie_ff & (flag_ff | set_flag) & !(go & !set_flag);
    end
  end

  a_flag_suspends: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_HOLD && flag_ff && !go && en_ff) |=> state_ff == S_HOLD)
    else $error("engine left hold while flag set");

  a_start_code: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_START_B && tick && en_ff && !rs_ff) |=>
      flag_ff && code_ff == CODE_START && state_ff == S_HOLD)
    else $error("start did not report 0x08");

  a_rstart_code: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_START_B && tick && en_ff && rs_ff) |=> code_ff == CODE_RSTART)
    else $error("repeated start did not report 0x10");

  a_w1c_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (go && !set_flag) |=> !flag_ff)
    else $error("flag not cleared by writing one");

  a_wcol_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_data && !flag_ff) |=> wc_ff && $stable(data_ff))
    else $error("collision write not discarded");

  a_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_STOP_C && tick && scl_s && en_ff) |=> !sto_ff && sda_oe_n)
    else $error("stop request not cleared after stop");

  a_free_bus: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_WAIT_FREE && busy_ff) |=> state_ff != S_START_A)
    else $error("start generated on busy bus");

  a_ack_code: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_BIT_HIGH && tick && scl_s && en_ff && bit_ff == 4'd8 && !addr_ff)
      |=> flag_ff && (code_ff == CODE_DAT_ACK || code_ff == CODE_DAT_NACK))
    else $error("data byte end code wrong");

  a_arb_lost: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_BIT_HIGH && tick && scl_s && en_ff && bit_ff < 4'd8 &&
     !sda_low_ff && !sda_s) |=> code_ff == CODE_ARB_LOST && lost_ff ##1 sda_oe_n)
    else $error("arbitration loss not reported");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (ie_ff && flag_ff && !go) |=> irq)
    else $error("interrupt missing while flag set");

endmodule

// File: verif/twmt_slave.sv
`timescale 1ns/1ps
module twmt_slave (
  // bus wires
  input  wire logic scl,
  input  wire logic sda,
  // behaviour controls
  input  wire logic nack,
  input  wire logic grab,
  input  wire logic stretch,
  // open-drain pulls, low pulls the line
  output logic      sda_oe_n,
  output logic      scl_oe_n
);
  logic [7:0] sh;
  logic [7:0] rx_q[$];
  logic       act;
  logic       ack_n;
  int         cnt;
  int         stop_cnt;

  initial
  begin
    ack_n = 1'b1;
    scl_oe_n = 1'b1;
    act = 1'b0;
    cnt = 0;
    stop_cnt = 0;
    sh = 8'h00;
  end

  // grab holds data low to beat the master
  assign sda_oe_n = ack_n & ~grab;

  // start and stop: data edge while clock high
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      act = 1'b1;
      cnt = 0;
    end

  always @(posedge sda)
    if (scl === 1'b1 && act)
    begin
      act = 1'b0;
      stop_cnt++;
    end

  // msb first, sampled on rising clock
  always @(posedge scl)
    if (act)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      cnt++;
    end

  // ack low, nack released; optional clock stretch
  always @(negedge scl)
    if (act)
    begin
      if (cnt == 8)
        ack_n = nack;
      else if (cnt == 9)
      begin
        ack_n = 1'b1;
        rx_q.push_back(sh);
        cnt = 0;
      end
      if (stretch)
      begin
        scl_oe_n = 1'b0;
        #1200;
        scl_oe_n = 1'b1;
      end
    end
endmodule

// File: verif/twmt_tb_top.sv
`timescale 1ns/1ps
module twmt_tb_top;
  import twmt_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_oe_n;
  logic        sda_oe_n;
  logic        s_scl_oe_n;
  logic        s_sda_oe_n;
  logic        irq;
  logic        nack;
  logic        grab;
  logic        stretch;
  wire logic   scl_w = scl_oe_n & s_scl_oe_n;
  wire logic   sda_w = sda_oe_n & s_sda_oe_n;
  logic [31:0] rdat;
  logic        err_s;
  logic [31:0] rnd = 32'h00011315;
  logic [7:0]  exp_q[$];
  logic [31:0] rst_v[4] = '{{24'h0, CTRL_RESET}, {24'h0, CODE_IDLE}, {24'h0, DATA_RESET},
                            {24'h0, RATE_RESET}};
  int          err_count = 0;
  int          check_count = 0;
  int          sc;

  twmt_top #(.ADDR_W(8)) u_twmt_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(),
    .sda_oe_n(sda_oe_n), .irq(irq)
  );

  twmt_slave u_twmt_slave (
    .scl(scl_w), .sda(sda_w), .nack(nack), .grab(grab), .stretch(stretch),
    .sda_oe_n(s_sda_oe_n), .scl_oe_n(s_scl_oe_n)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err_s = pslverr;
    chk("pready", pready, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, rdat);
  endtask

  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0, rdat);
      n++;
    end
    while ((rdat[7:0] & m) !== v && n < 300);
    chk("poll", rdat[7:0] & m, v);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    logic [31:0] v;
    v = s;
    for (int k = 0; k < 8; k++)
      v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    return v;
  endfunction

  task automatic nxt();
    rnd = lfsr(rnd);
  endtask

  task automatic send(input logic [7:0] b, input logic nk, input logic [7:0] code,
                      input logic coll);
    nack <= nk;
    exp_q.push_back(b);
    wr(ADDR_DATA, b);
    wr(ADDR_CTRL, 8'h85);
    if (coll)
    begin
      wr(ADDR_DATA, ~b);
      apb(1'b0, ADDR_CTRL, 32'h0, rdat);
      chk("wc", rdat[CTRL_WC], 1);
      apb(1'b0, ADDR_DATA, 32'h0, rdat);
      chk("kept", rdat, {24'h0, b});
    end
    poll(ADDR_CTRL, 8'h80, 8'h80);
    chk("irq", irq, 1);
    chk("rxn", u_twmt_slave.rx_q.size(), exp_q.size());
    chk("rx", u_twmt_slave.rx_q[$], b);
    poll(ADDR_STAT, 8'hf8, code);
  endtask

  initial
  begin
    #(20000 * 50);
    err_count++;
    stop_test();
  end

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nack = 1'b0;
    grab = 1'b0;
    stretch = 1'b0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("lines", {scl_oe_n, sda_oe_n, irq}, 3'b110);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0, rdat);
      chk("reset", rdat, rst_v[i]);
    end
    apb(1'b0, 8'h10, 32'h0, rdat);
    chk("slverr", err_s, 1);
    chk("unmapped", rdat, 0);
    wr(ADDR_STAT, 8'h03);
    apb(1'b0, ADDR_STAT, 32'h0, rdat);
    chk("presc", rdat, 32'h000000fb);
    wr(ADDR_CTRL, 8'ha4);
    poll(ADDR_CTRL, 8'h80, 8'h80);
    poll(ADDR_STAT, 8'hf8, CODE_START);
    repeat (40) @(posedge pclk);
    chk("held", scl_oe_n, 0);
    chk("idle_rx", u_twmt_slave.rx_q.size(), 0);
    stretch <= 1'b1;
    nxt();
    send({rnd[6:0], 1'b0}, 1'b0, CODE_SLA_ACK, 1'b0);
    stretch <= 1'b0;
    apb(1'b0, ADDR_RATE, 32'h0, rdat);
    chk("mode", rdat, {22'h0, 2'b01, RATE_RESET});
    for (int i = 0; i < 3; i++)
    begin
      nxt();
      send(rnd[7:0], i == 2, (i == 2) ? CODE_DAT_NACK : CODE_DAT_ACK, i == 1);
    end
    sc = u_twmt_slave.stop_cnt;
    wr(ADDR_CTRL, 8'ha5);
    poll(ADDR_CTRL, 8'h80, 8'h80);
    poll(ADDR_STAT, 8'hf8, CODE_RSTART);
    nxt();
    send({rnd[6:0], 1'b0}, 1'b1, CODE_SLA_NACK, 1'b0);
    chk("no_stop", u_twmt_slave.stop_cnt, sc);
    wr(ADDR_CTRL, 8'h95);
    poll(ADDR_CTRL, 8'h90, 8'h00);
    poll(ADDR_STAT, 8'hff, 8'hfb);
    chk("stop", u_twmt_slave.stop_cnt, sc + 1);
    chk("free", {scl_w, sda_w}, 2'b11);
    chk("irq_off", irq, 0);
    wr(ADDR_CTRL, 8'h84);
    apb(1'b0, ADDR_CTRL, 32'h0, rdat);
    chk("w1c", rdat[CTRL_FLAG], 0);
    wr(ADDR_CTRL, 8'ha4);
    poll(ADDR_CTRL, 8'h80, 8'h80);
    grab <= 1'b1;
    wr(ADDR_DATA, 8'hff);
    wr(ADDR_CTRL, 8'h84);
    poll(ADDR_CTRL, 8'h80, 8'h80);
    poll(ADDR_STAT, 8'hf8, CODE_ARB_LOST);
    grab <= 1'b0;
    wr(ADDR_CTRL, 8'h84);
    poll(ADDR_STAT, 8'hf8, CODE_IDLE);
    apb(1'b0, ADDR_RATE, 32'h0, rdat);
    chk("nas", rdat[9:8], 0);
    chk("rel", {scl_w, sda_w}, 2'b11);
    stop_test();
  end
endmodule
